// ===== verilog/lbd_pkg.sv
// Constants, register map and types of the LED blink and dimming timer
package lbd_pkg;
    // ==================================================================
    // Clock and timing
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned PWM_SLOT_NS   = 250_000;
    localparam int unsigned PWM_PERIOD_MS = 8;
    localparam int unsigned STEP_MS       = 64;
    localparam int unsigned SLOT_CYC_DFLT = PWM_SLOT_NS / 1000 * (CLK_HZ / 1_000_000);
    localparam int unsigned STEP_PERIODS  = STEP_MS / PWM_PERIOD_MS;
    localparam int unsigned SLOT_CNT_W    = 16;

    // ==================================================================
    // Field widths, masks and values
    localparam int unsigned DUTY_W    = 5;
    localparam int unsigned ON_W      = 5;
    localparam int unsigned LEN_W     = 7;
    localparam int unsigned CUR_W     = 4;
    localparam int unsigned RAMP_BIT  = 5;
    localparam logic [7:0]  REG_RESET = 8'h00;
    localparam logic [7:0]  MASK_5B   = 8'h1f;
    localparam logic [7:0]  MASK_7B   = 8'h7f;
    localparam logic [7:0]  MASK_RC   = 8'h2f;
    localparam logic [4:0]  LEVEL_MAX = 5'h1f;
    localparam logic [4:0]  LEVEL_MIN = 5'h00;
    localparam logic [6:0]  LEN_ZERO  = 7'h00;
    localparam logic [6:0]  LEN_ONE   = 7'h01;

    // ==================================================================
    // Register offsets
    localparam logic [7:0] OFF_A_PHASE1 = 8'h48;
    localparam logic [7:0] OFF_A_PERIOD = 8'h4c;
    localparam logic [7:0] OFF_A_DUTY   = 8'h4d;
    localparam logic [7:0] OFF_A_ONDUR  = 8'h4e;
    localparam logic [7:0] OFF_B_RAMPC  = 8'h4f;
    localparam logic [7:0] OFF_B_PH1    = 8'h50;
    localparam logic [7:0] OFF_B_PH2    = 8'h51;
    localparam logic [7:0] OFF_B_PH3    = 8'h52;

    // ==================================================================
    // Channel B sequence phases, Gray coded
    typedef enum logic [1:0] {
        LBD_PH1 = 2'b00,
        LBD_PH2 = 2'b01,
        LBD_PH3 = 2'b11
    } lbd_phase_t;
endpackage

// ===== verilog/lbd_tick_if.sv
// Timebase ticks shared between the divider and the LED sequencer
`timescale 1ns/1ps
`default_nettype none
interface lbd_tick_if;
    logic       slotTick;
    logic       periodTick;
    logic       stepTick;
    logic [4:0] slotIdx;
    modport src (output slotTick, output periodTick, output stepTick, output slotIdx);
    modport snk (input slotTick, input periodTick, input stepTick, input slotIdx);
endinterface
`default_nettype wire

// ===== verilog/lbd_timebase.sv
// Divider making the 250 us slot, 8 ms period and 64 ms step enables
`timescale 1ns/1ps
`default_nettype none
module lbd_timebase #(
    parameter int unsigned SLOT_CYCLES = lbd_pkg::SLOT_CYC_DFLT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Ticks
    lbd_tick_if.src   tick
);
    import lbd_pkg::*;

    localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYCLES - 1);
    localparam logic [2:0]            STEP_LAST = 3'(STEP_PERIODS - 1);

    logic [SLOT_CNT_W-1:0] divCnt_r;
    logic [4:0]            slotIdx_r;
    logic [2:0]            perCnt_r;
    logic                  slotHit;

    assign slotHit         = (divCnt_r == SLOT_LAST);
    assign tick.slotTick   = slotHit;
    assign tick.slotIdx    = slotIdx_r;
    assign tick.periodTick = slotHit && (slotIdx_r == LEVEL_MAX);
    assign tick.stepTick   = tick.periodTick && (perCnt_r == STEP_LAST);

    always_ff @(posedge clk)
    begin
        if (srst || slotHit)
            divCnt_r <= '0;
        else
            divCnt_r <= divCnt_r + 1'b1;
    end

    // Slot index wraps by itself after 32 slots, one 8 ms period
    always_ff @(posedge clk)
    begin
        if (srst)
            slotIdx_r <= '0;
        else if (slotHit)
            slotIdx_r <= slotIdx_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst || tick.stepTick)
            perCnt_r <= '0;
        else if (tick.periodTick)
            perCnt_r <= perCnt_r + 1'b1;
    end

    a_step_spacing : assert property (@(posedge clk) disable iff (srst)
        tick.stepTick |-> tick.periodTick && tick.slotTick)
        else $error("step tick outside a period boundary");
endmodule
`default_nettype wire

// ===== verilog/lbd_led_timer.sv
// LED blink and dimming timer: registers, channel A PWM, channel B sequence
//
// How it works
// - Channel A drive is PWM, 8 ms period, high for (code+1)/32.
// - Code zero gives 250 us high, 7.75 ms low each period.
// - Code all ones keeps channel A drive high without a gap.
// - Channel A lit window lasts on-duration field times 64 ms.
// - Channel B ramps brightness only when ramp enable is one.
// - Channel B sink current code comes from low four register bits.
// - Channel B first phase lasts its 7-bit field times 64 ms.
// - Channel B second phase lasts its 7-bit field times 64 ms.
// - Channel B third phase lasts its 7-bit field times 64 ms.
// - Unused bits read zero and ignore writes.
// - All timing and control registers clear to zero on reset.
// - Channel A first phase lasts its 7-bit field times 64 ms.
// - Channel A sequence period is its 7-bit field times 64 ms.
`timescale 1ns/1ps
`default_nettype none
module lbd_led_timer #(
    parameter int unsigned SLOT_CYCLES = lbd_pkg::SLOT_CYC_DFLT
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Register port
    input  wire logic                     regWrEn,
    input  wire logic                     regRdEn,
    input  wire logic [7:0]               regAddr,
    input  wire logic [7:0]               regWrData,
    output logic      [7:0]               regRdData,
    // LED controls
    output logic                          chanADriveSignal,
    output logic                          chanBDriveSignal,
    output logic      [lbd_pkg::CUR_W-1:0] chanBSinkCurrentCode,
    output logic                          chanBRampEn
);
    import lbd_pkg::*;

    // ==================================================================
    // Timebase
    lbd_tick_if tick ();

    lbd_timebase #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_timebase (
        .clk  (clk),
        .srst (srst),
        .tick (tick.src)
    );

    // ==================================================================
    // Registers
    logic [7:0] aPhase1_r;
    logic [7:0] aPeriod_r;
    logic [7:0] aDuty_r;
    logic [7:0] aOnDur_r;
    logic [7:0] bRampCur_r;
    logic [7:0] bPh1_r;
    logic [7:0] bPh2_r;
    logic [7:0] bPh3_r;
    logic [7:0] rdMux;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aPhase1_r  <= REG_RESET;
            aPeriod_r  <= REG_RESET;
            aDuty_r    <= REG_RESET;
            aOnDur_r   <= REG_RESET;
            bRampCur_r <= REG_RESET;
            bPh1_r     <= REG_RESET;
            bPh2_r     <= REG_RESET;
            bPh3_r     <= REG_RESET;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                OFF_A_PHASE1: aPhase1_r  <= regWrData & MASK_7B;
                OFF_A_PERIOD: aPeriod_r  <= regWrData & MASK_7B;
                OFF_A_DUTY:   aDuty_r    <= regWrData & MASK_5B;
                OFF_A_ONDUR:  aOnDur_r   <= regWrData & MASK_5B;
                OFF_B_RAMPC:  bRampCur_r <= regWrData & MASK_RC;
                OFF_B_PH1:    bPh1_r     <= regWrData & MASK_7B;
                OFF_B_PH2:    bPh2_r     <= regWrData & MASK_7B;
                OFF_B_PH3:    bPh3_r     <= regWrData & MASK_7B;
                default:      ;
            endcase
        end
    end

    always_comb
    begin
        case (regAddr)
            OFF_A_PHASE1: rdMux = aPhase1_r;
            OFF_A_PERIOD: rdMux = aPeriod_r;
            OFF_A_DUTY:   rdMux = aDuty_r;
            OFF_A_ONDUR:  rdMux = aOnDur_r;
            OFF_B_RAMPC:  rdMux = bRampCur_r;
            OFF_B_PH1:    rdMux = bPh1_r;
            OFF_B_PH2:    rdMux = bPh2_r;
            OFF_B_PH3:    rdMux = bPh3_r;
            default:      rdMux = REG_RESET;
        endcase
    end

    // Read data held until the next read, so a slow master can sample late
    always_ff @(posedge clk)
    begin
        if (srst)
            regRdData <= REG_RESET;
        else if (regRdEn)
            regRdData <= rdMux;
    end

    // ==================================================================
    // Channel A: period counter, lit window, PWM
    logic [LEN_W-1:0]  stepA_r;
    logic [DUTY_W-1:0] dutyQ_r;
    logic [7:0]        winEnd;
    logic              aLit;
    logic [LEN_W-1:0]  aPer;
    logic [LEN_W-1:0]  aT1;

    assign aPer   = aPeriod_r[LEN_W-1:0];
    assign aT1    = aPhase1_r[LEN_W-1:0];
    assign winEnd = {1'b0, aT1} + {3'b000, aOnDur_r[ON_W-1:0]};
    assign aLit   = (stepA_r >= aT1) && ({1'b0, stepA_r} < winEnd);

    // Zero period restarts every step, leaving only the phase-one offset
    always_ff @(posedge clk)
    begin
        if (srst)
            stepA_r <= LEN_ZERO;
        else if (tick.stepTick)
        begin
            if (aPer == LEN_ZERO || stepA_r >= aPer - LEN_ONE)
                stepA_r <= LEN_ZERO;
            else
                stepA_r <= stepA_r + LEN_ONE;
        end
    end

    // Duty taken only at the period boundary to avoid a clipped pulse
    always_ff @(posedge clk)
    begin
        if (srst)
            dutyQ_r <= LEVEL_MIN;
        else if (tick.periodTick)
            dutyQ_r <= aDuty_r[DUTY_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            chanADriveSignal <= 1'b0;
        else
            chanADriveSignal <= aLit && (tick.slotIdx <= dutyQ_r);
    end

    // ==================================================================
    // Channel B: three-phase sequence with optional ramp
    lbd_phase_t        phB_r;
    logic [LEN_W-1:0]  cntB_r;
    logic [4:0]        levB_r;
    logic [LEN_W-1:0]  lenB;
    logic              phDone;
    logic              rampOn;

    assign rampOn               = bRampCur_r[RAMP_BIT];
    assign chanBRampEn          = rampOn;
    assign chanBSinkCurrentCode = bRampCur_r[CUR_W-1:0];

    always_comb
    begin
        case (phB_r)
            LBD_PH1: lenB = bPh1_r[LEN_W-1:0];
            LBD_PH2: lenB = bPh2_r[LEN_W-1:0];
            LBD_PH3: lenB = bPh3_r[LEN_W-1:0];
            default: lenB = LEN_ZERO;
        endcase
    end

    // An empty phase is skipped on the next clock
    assign phDone = (lenB == LEN_ZERO) || (tick.stepTick && cntB_r >= lenB - LEN_ONE);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phB_r  <= LBD_PH1;
            cntB_r <= LEN_ZERO;
        end
        else if (phDone)
        begin
            cntB_r <= LEN_ZERO;
            case (phB_r)
                LBD_PH1: phB_r <= LBD_PH2;
                LBD_PH2: phB_r <= LBD_PH3;
                LBD_PH3: phB_r <= LBD_PH1;
                default: phB_r <= LBD_PH1;
            endcase
        end
        else if (tick.stepTick)
            cntB_r <= cntB_r + LEN_ONE;
    end

    // Ramp moves one level per 8 ms period: full swing takes 248 ms
    always_ff @(posedge clk)
    begin
        if (srst)
            levB_r <= LEVEL_MIN;
        else if (phB_r == LBD_PH2)
            levB_r <= LEVEL_MAX;
        else if (!rampOn)
            levB_r <= (phB_r == LBD_PH1) ? LEVEL_MAX : LEVEL_MIN;
        else if (tick.periodTick && phB_r == LBD_PH1 && levB_r != LEVEL_MAX)
            levB_r <= levB_r + 1'b1;
        else if (tick.periodTick && phB_r == LBD_PH3 && levB_r != LEVEL_MIN)
            levB_r <= levB_r - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            chanBDriveSignal <= 1'b0;
        else
            chanBDriveSignal <= (lenB != LEN_ZERO) && (phB_r != LBD_PH3 ||
                (rampOn && levB_r != LEVEL_MIN)) && (tick.slotIdx <= levB_r);
    end

    // ==================================================================
    // Checks
    a_duty_fraction : assert property (@(posedge clk) disable iff (srst)
        (aLit && tick.slotIdx > dutyQ_r) |=> !chanADriveSignal)
        else $error("channel A high past its duty slot");

    a_duty_zero_pulse : assert property (@(posedge clk) disable iff (srst)
        (aLit && dutyQ_r == LEVEL_MIN) |=> chanADriveSignal == ($past(tick.slotIdx) == 5'h00))
        else $error("code zero pulse is not one 250 us slot");

    a_duty_full_on : assert property (@(posedge clk) disable iff (srst)
        (aLit && dutyQ_r == LEVEL_MAX) |=> chanADriveSignal)
        else $error("full duty code shows a low interval");

    a_window_dark : assert property (@(posedge clk) disable iff (srst)
        (!aLit || aOnDur_r[ON_W-1:0] == 5'h00) |=> !chanADriveSignal)
        else $error("channel A driven outside its lit window");

    a_period_wrap : assert property (@(posedge clk) disable iff (srst)
        (tick.stepTick && aPer != LEN_ZERO && stepA_r == aPer - LEN_ONE) |=> stepA_r == LEN_ZERO)
        else $error("channel A period did not restart");

    a_duty_latch : assert property (@(posedge clk) disable iff (srst)
        (dutyQ_r != $past(dutyQ_r)) |-> $past(tick.periodTick))
        else $error("duty changed inside a PWM period");

    a_noramp_switch : assert property (@(posedge clk) disable iff (srst)
        (!rampOn && phB_r == LBD_PH3) ##1 (!rampOn && phB_r == LBD_PH3) |=> !chanBDriveSignal)
        else $error("channel B dims without ramp enable");

    a_phase_skip : assert property (@(posedge clk) disable iff (srst)
        (phB_r == LBD_PH1 && bPh1_r[LEN_W-1:0] == LEN_ZERO) |=> phB_r == LBD_PH2)
        else $error("empty first phase not skipped");

    a_phase_hold : assert property (@(posedge clk) disable iff (srst)
        (phB_r == LBD_PH2 && !tick.stepTick && lenB != LEN_ZERO) |=> phB_r == LBD_PH2)
        else $error("second phase ended between steps");

    a_unused_zero : assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == OFF_A_DUTY) |=> regRdData[7:DUTY_W] == 3'b000)
        else $error("unused bits read nonzero");

    a_reset_clear : assert property (@(posedge clk)
        srst |=> (aDuty_r == REG_RESET && bRampCur_r == REG_RESET && bPh3_r == REG_RESET))
        else $error("registers not cleared by reset");
endmodule
`default_nettype wire

// ===== bench/lbd_led_timer_tb_top.sv
// Self-checking bench for the LED blink and dimming timer
`timescale 1ns/1ps
`default_nettype none
module lbd_led_timer_tb_top;
    import lbd_pkg::*;
    // ==========================================================
    // Timing: a short slot keeps one 64 ms step at 1024 clocks
    localparam int SC   = 4;
    localparam int PER  = 32 * SC;
    localparam int STEP = 8 * PER;
    localparam logic [7:0] ADDR [8] = '{OFF_A_PHASE1, OFF_A_PERIOD, OFF_A_DUTY, OFF_A_ONDUR,
                                        OFF_B_RAMPC, OFF_B_PH1, OFF_B_PH2, OFF_B_PH3};
    localparam logic [7:0] MASK [8] = '{MASK_7B, MASK_7B, MASK_5B, MASK_5B,
                                        MASK_RC, MASK_7B, MASK_7B, MASK_7B};

    logic       clk;
    logic       srst;
    logic       regWrEn;
    logic       regRdEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       chanADriveSignal;
    logic       chanBDriveSignal;
    logic [3:0] chanBSinkCurrentCode;
    logic       chanBRampEn;
    int         errorCnt;
    int         testsRun;

    lbd_led_timer #(.SLOT_CYCLES(SC)) dut (
        .clk                 (clk),
        .srst                (srst),
        .regWrEn             (regWrEn),
        .regRdEn             (regRdEn),
        .regAddr             (regAddr),
        .regWrData           (regWrData),
        .regRdData           (regRdData),
        .chanADriveSignal    (chanADriveSignal),
        .chanBDriveSignal    (chanBDriveSignal),
        .chanBSinkCurrentCode(chanBSinkCurrentCode),
        .chanBRampEn         (chanBRampEn)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic stopTest;
        if (errorCnt == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkCnt(input int got, input int exp);
        testsRun++;
        if (got != exp)
        begin
            errorCnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Returns one small delay after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        tick(1);
        regWrEn   = 1'b0;
        tick(1);
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        tick(1);
        regRdEn = 1'b0;
        tick(1);
        d = regRdData;
    endtask

    // Window of whole repeats, so the count does not depend on phase
    task automatic countHigh(input bit chanB, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            c += chanB ? int'(chanBDriveSignal === 1'b1) : int'(chanADriveSignal === 1'b1);
            tick(1);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic regAccess;
        logic [7:0] d;
        foreach (ADDR[i])
        begin
            rdReg(ADDR[i], d);
            chk8(d, REG_RESET);
            wrReg(ADDR[i], 8'hff);
            rdReg(ADDR[i], d);
            chk8(d, MASK[i]);
        end
        chk8({4'h0, chanBSinkCurrentCode}, 8'h0f);
        chk8({7'h0, chanBRampEn}, 8'h01);
        wrReg(OFF_B_RAMPC, 8'hd9);
        chk8({4'h0, chanBSinkCurrentCode}, 8'h09);
        chk8({7'h0, chanBRampEn}, 8'h00);
        wrReg(8'h53, 8'hff);
        rdReg(8'h53, d);
        chk8(d, 8'h00);
        foreach (ADDR[i])
            wrReg(ADDR[i], 8'h00);
    endtask

    task automatic chanAPwm;
        int c;
        logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h0f, 5'h1f};
        wrReg(OFF_A_ONDUR, 8'h01);
        foreach (codes[i])
        begin
            wrReg(OFF_A_DUTY, {3'h0, codes[i]});
            tick(2 * PER);
            countHigh(1'b0, PER, c);
            chkCnt(c, (int'(codes[i]) + 1) * SC);
        end
        wrReg(OFF_A_ONDUR, 8'h00);
        tick(2 * PER);
        countHigh(1'b0, PER, c);
        chkCnt(c, 0);
    endtask

    // Lit for two steps out of a four-step period, one step late
    task automatic chanAWindow;
        int c;
        wrReg(OFF_A_PERIOD, 8'h04);
        wrReg(OFF_A_PHASE1, 8'h01);
        wrReg(OFF_A_ONDUR, 8'h02);
        tick(4 * STEP);
        countHigh(1'b0, 4 * STEP, c);
        chkCnt(c, 2 * STEP);
    endtask

    task automatic chanBPhases;
        int c;
        wrReg(OFF_B_PH1, 8'h01);
        wrReg(OFF_B_PH2, 8'h01);
        wrReg(OFF_B_PH3, 8'h02);
        tick(4 * STEP);
        countHigh(1'b1, 4 * STEP, c);
        chkCnt(c, 2 * STEP);
        wrReg(OFF_B_PH1, 8'h02);
        wrReg(OFF_B_PH3, 8'h01);
        tick(4 * STEP);
        countHigh(1'b1, 4 * STEP, c);
        chkCnt(c, 3 * STEP);
    endtask

    // One level per 8 ms: fall 31..16, rise 15..22, hold full in between
    task automatic chanBRamp;
        int c;
        wrReg(OFF_B_PH1, 8'h01);
        wrReg(OFF_B_PH3, 8'h02);
        wrReg(OFF_B_RAMPC, 8'h20);
        tick(4 * STEP);
        countHigh(1'b1, 4 * STEP, c);
        chkCnt(c, (392 + 256 + 156) * SC);
    endtask

    task automatic midReset;
        logic [7:0] d;
        wrReg(OFF_A_DUTY, 8'h1f);
        srst = 1'b1;
        tick(3);
        chk8({6'h0, chanADriveSignal, chanBDriveSignal}, 8'h00);
        chk8({3'h0, chanBRampEn, chanBSinkCurrentCode}, 8'h00);
        srst = 1'b0;
        tick(1);
        foreach (ADDR[i])
        begin
            rdReg(ADDR[i], d);
            chk8(d, REG_RESET);
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        srst      = 1'b1;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
        errorCnt  = 0;
        testsRun  = 0;
        tick(3);
        srst = 1'b0;
        tick(1);
        regAccess();
        chanAPwm();
        chanAWindow();
        chanBPhases();
        chanBRamp();
        midReset();
        stopTest();
    end

    initial
    begin
        #(60000 * 25);
        errorCnt++;
        stopTest();
    end
endmodule
`default_nettype wire
